// File: verilog/fpec_cfg.svh
// Offsets, bit positions, reset values and address map of the flash control
`ifndef FPEC_CFG_SVH
`define FPEC_CFG_SVH
`define FPEC_OFF_CTRL   12'h000
`define FPEC_OFF_ADDR   12'h004
`define FPEC_OFF_PROT   12'h008
`define FPEC_OFF_STAT   12'h00C
`define FPEC_B_PGM      0
`define FPEC_B_ERASE    1
`define FPEC_B_MARGIN_SELECT     2
`define FPEC_B_HV       3
`define FPEC_B_SZLO     4
`define FPEC_B_SZHI     5
`define FPEC_B_DIVLO    6
`define FPEC_B_DIVHI    7
`define FPEC_CTRL_RST   8'h00
`define FPEC_PROT_RST   4'h0
`define FPEC_A1_LO      16'h8000
`define FPEC_A1_MAIN_HI 16'hFDFF
`define FPEC_A1_VEC_LO  16'hFFDE
`define FPEC_A1_BYTES   32290
`define FPEC_A1_ROWLAST 511
`define FPEC_A2_LO      16'h3E00
`define FPEC_A2_HI      16'h7FFF
`define FPEC_A2_BYTES   16896
`define FPEC_A2_ROWLAST 263
`define FPEC_HALF_MASK  16'h3FFF
`define FPEC_OCT_MASK   16'h01FF
`define FPEC_ROW_MASK   16'h003F
`define FPEC_PAGE_MASK  16'h0007
`define FPEC_PROT_B3    16'hC000
`define FPEC_PROT_B2    16'hA000
`define FPEC_PROT_B1    16'h9000
`define FPEC_PROT_B0    16'h8000
`endif

// File: verilog/fpec_pkg.sv
// Types shared by the flash control logic
`default_nettype none
package fpec_pkg;
    typedef logic [15:0] fpec_addr_t;
    typedef enum logic [1:0] {
        FPEC_SZ_FULL = 2'b00,
        FPEC_SZ_HALF = 2'b01,
        FPEC_SZ_OCT  = 2'b10,
        FPEC_SZ_ROW  = 2'b11
    } fpec_size_e;
endpackage : fpec_pkg
`default_nettype wire

// File: verilog/fpec_ctrl.sv
// Flash program/erase control register, interlocks and target latch
// Summary of operation
// - Array reads give 0 for erased bits, 1 for programmed bits.
// - Rows hold 8 pages of 8 bytes, 64 bytes per row.
// - One program operation writes one 8-byte page.
// - Erase never covers less than one whole 64-byte row.
// - First array holds 32290 bytes in rows 0 to 511.
// - Second array holds 16,896 bytes in rows 0 to 263.
// - Low divide bit picks pump clock divide; high bit does nothing.
// - Erase size: full array, half, eight rows, or one row.
// - Array write in erase setup latches the block; full takes any address.
// - High voltage set only while program or erase is selected.
// - Margin refused while high voltage on; cleared when it turns on.
// - Program and erase select never both one; such a write fails.
// - Protected target range clears the select bit, blocking high voltage.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_cfg.svh"
module fpec_ctrl
    import fpec_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Processor writes and reads into the array
    input  wire logic        aw_i,
    input  wire logic [15:0] aw_addr_i,
    input  wire logic [7:0]  aw_data_i,
    input  wire logic        ar_i,
    input  wire logic [7:0]  cell_erased_i,
    output logic [7:0]       arr_rdata_o,
    // Array and pump controls
    output logic             hv_on_o,
    output logic             pump_div_low_o,
    output logic [1:0]       erase_size_o,
    output logic             erase_mode_o,
    output logic             prog_mode_o,
    output logic             margin_o,
    output logic [15:0]      target_addr_o,
    output logic             target_valid_o,
    output logic [8:0]       target_row_o,
    output logic [63:0]      page_data_o,
    output logic [7:0]       page_mask_o
);

    logic [7:0]  ctrl_q;
    logic [3:0]  prot_q;
    logic [15:0] tgt_q;
    logic        tgt_v_q;
    logic [7:0]  page_buf_q [8];
    logic [7:0]  mask_q;
    logic [7:0]  rdata_q;
    logic [31:0] prdata_q;
    logic        err_q;

    // Address in the first array: main area or vector area
    function automatic logic in_a1(input fpec_addr_t a);
        in_a1 = (a >= `FPEC_A1_LO && a <= `FPEC_A1_MAIN_HI) || (a >= `FPEC_A1_VEC_LO);
    endfunction : in_a1

    // Second array answers to its own control register, never latched here
    function automatic logic in_a2(input fpec_addr_t a);
        in_a2 = (a >= `FPEC_A2_LO && a <= `FPEC_A2_HI);
    endfunction : in_a2

    // Lowest protect base among set bits; bit 0 reaches furthest down
    function automatic fpec_addr_t prot_base(input logic [3:0] p);
        if (p[0])
            prot_base = `FPEC_PROT_B0;
        else if (p[1])
            prot_base = `FPEC_PROT_B1;
        else if (p[2])
            prot_base = `FPEC_PROT_B2;
        else
            prot_base = `FPEC_PROT_B3;
    endfunction : prot_base

    // Protected ranges all run to the top, so only the range end matters
    function automatic logic prot_hit(input fpec_addr_t e, input logic [3:0] p);
        prot_hit = (|p) && (e >= prot_base(p));
    endfunction : prot_hit

    // Erase block base from the size field
    function automatic fpec_addr_t blk_base(input fpec_addr_t a, input logic [1:0] s);
        case (fpec_size_e'(s))
            FPEC_SZ_FULL: blk_base = `FPEC_A1_LO;
            FPEC_SZ_HALF: blk_base = a & ~`FPEC_HALF_MASK;
            FPEC_SZ_OCT:  blk_base = a & ~`FPEC_OCT_MASK;
            default:      blk_base = a & ~`FPEC_ROW_MASK;
        endcase
    endfunction : blk_base

    // Last byte of the erase block
    function automatic fpec_addr_t blk_end(input fpec_addr_t a, input logic [1:0] s);
        case (fpec_size_e'(s))
            FPEC_SZ_FULL: blk_end = 16'hFFFF;
            FPEC_SZ_HALF: blk_end = a | `FPEC_HALF_MASK;
            FPEC_SZ_OCT:  blk_end = a | `FPEC_OCT_MASK;
            default:      blk_end = a | `FPEC_ROW_MASK;
        endcase
    endfunction : blk_end

    // Bus decode; zero-wait slave, answer stands in the access cycle
    logic sel_ctrl;
    logic sel_addr;
    logic sel_prot;
    logic sel_stat;
    logic mapped;
    logic wr_acc;
    assign sel_ctrl = (paddr_i == `FPEC_OFF_CTRL);
    assign sel_addr = (paddr_i == `FPEC_OFF_ADDR);
    assign sel_prot = (paddr_i == `FPEC_OFF_PROT);
    assign sel_stat = (paddr_i == `FPEC_OFF_STAT);
    assign mapped   = sel_ctrl | sel_addr | sel_prot | sel_stat;
    assign wr_acc   = psel_i & penable_i & pwrite_i & mapped & pstrb_i[0];

    // Control byte write decode and interlocks
    logic [7:0] wd;
    logic       wr_ctrl;
    logic       both_sel;
    logic       pgm_w;
    logic       ers_w;
    logic       hv_w;
    logic       margin_select_w;
    assign wd       = pwdata_i[7:0];
    assign wr_ctrl  = wr_acc & sel_ctrl;
    assign both_sel = wd[`FPEC_B_PGM] & wd[`FPEC_B_ERASE];
    // A write asking for both keeps the old selects untouched
    assign pgm_w    = both_sel ? ctrl_q[`FPEC_B_PGM] : wd[`FPEC_B_PGM];
    assign ers_w    = both_sel ? ctrl_q[`FPEC_B_ERASE] : wd[`FPEC_B_ERASE];
    // Select must already be held before this write
    assign hv_w     = wd[`FPEC_B_HV] & (ctrl_q[`FPEC_B_PGM] | ctrl_q[`FPEC_B_ERASE]);
    assign margin_select_w   = wd[`FPEC_B_MARGIN_SELECT] & ~ctrl_q[`FPEC_B_HV] & ~hv_w;

    // Array write acceptance; only while high voltage is still off
    logic       arr_wr;
    logic       hit_ers;
    logic       hit_pgm;
    fpec_addr_t ebase;
    fpec_addr_t pbase;
    assign arr_wr  = aw_i & in_a1(aw_addr_i) & ~in_a2(aw_addr_i) & ~ctrl_q[`FPEC_B_HV];
    assign ebase   = blk_base(aw_addr_i, ctrl_q[`FPEC_B_SZHI:`FPEC_B_SZLO]);
    assign pbase   = aw_addr_i & ~`FPEC_PAGE_MASK;
    assign hit_ers = arr_wr & ctrl_q[`FPEC_B_ERASE]
                   & prot_hit(blk_end(ebase, ctrl_q[`FPEC_B_SZHI:`FPEC_B_SZLO]), prot_q);
    assign hit_pgm = arr_wr & ctrl_q[`FPEC_B_PGM] & prot_hit(pbase | `FPEC_PAGE_MASK, prot_q);

    // Control register; protection clear overrides a same-cycle write
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            ctrl_q <= `FPEC_CTRL_RST;
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q[`FPEC_B_DIVHI]                <= wd[`FPEC_B_DIVHI];
                ctrl_q[`FPEC_B_DIVLO]                <= wd[`FPEC_B_DIVLO];
                ctrl_q[`FPEC_B_SZHI:`FPEC_B_SZLO]    <= wd[`FPEC_B_SZHI:`FPEC_B_SZLO];
                // A protection hit in the same cycle also blocks the pump
                ctrl_q[`FPEC_B_HV]                   <= hv_w & ~hit_ers & ~hit_pgm;
                ctrl_q[`FPEC_B_MARGIN_SELECT]                 <= margin_select_w;
                ctrl_q[`FPEC_B_ERASE]                <= ers_w;
                ctrl_q[`FPEC_B_PGM]                  <= pgm_w;
            end
            else if (ctrl_q[`FPEC_B_HV])
                ctrl_q[`FPEC_B_MARGIN_SELECT] <= 1'b0;
            if (hit_ers)
                ctrl_q[`FPEC_B_ERASE] <= 1'b0;
            if (hit_pgm)
                ctrl_q[`FPEC_B_PGM] <= 1'b0;
        end
    end

    // Protect register, software owned
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            prot_q <= `FPEC_PROT_RST;
        else if (wr_acc & sel_prot)
            prot_q <= pwdata_i[3:0];
    end

    // Target latch; dropped once neither mode is selected
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            tgt_q   <= 16'h0000;
            tgt_v_q <= 1'b0;
        end
        else if (~ctrl_q[`FPEC_B_PGM] & ~ctrl_q[`FPEC_B_ERASE])
            tgt_v_q <= 1'b0;
        else if (arr_wr & ctrl_q[`FPEC_B_ERASE] & ~hit_ers)
        begin
            tgt_q   <= ebase;
            tgt_v_q <= 1'b1;
        end
        else if (arr_wr & ctrl_q[`FPEC_B_PGM] & ~hit_pgm)
        begin
            tgt_q   <= pbase;
            tgt_v_q <= 1'b1;
        end
    end

    // Page buffer; a write to another page restarts the buffer
    always_ff @(posedge mclk_i)
    begin
        if (srst_i | ~ctrl_q[`FPEC_B_PGM])
            mask_q <= 8'h00;
        else if (arr_wr & ~hit_pgm)
        begin
            if (tgt_v_q && tgt_q != pbase)
                mask_q <= 8'h01 << aw_addr_i[2:0];
            else
                mask_q[aw_addr_i[2:0]] <= 1'b1;
        end
    end

    // Page bytes; no reset needed, the mask qualifies them
    always_ff @(posedge mclk_i)
    begin
        if (arr_wr & ctrl_q[`FPEC_B_PGM] & ~hit_pgm)
            page_buf_q[aw_addr_i[2:0]] <= aw_data_i;
    end

    // Array read data; sense high means erased cell
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            rdata_q <= 8'h00;
        else if (ar_i)
            rdata_q <= ~cell_erased_i;
    end

    // Read data prepared in the setup cycle so it comes from flops
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            prdata_q <= 32'h0000_0000;
            err_q    <= 1'b0;
        end
        else if (psel_i & ~penable_i)
        begin
            err_q <= ~mapped;
            if (sel_ctrl)
                prdata_q <= {24'h00_0000, ctrl_q};
            else if (sel_addr)
                prdata_q <= {16'h0000, tgt_q};
            else if (sel_prot)
                prdata_q <= {28'h000_0000, prot_q};
            else if (sel_stat)
                prdata_q <= {16'h0000, mask_q, 5'h00, ctrl_q[`FPEC_B_HV], |mask_q, tgt_v_q};
            else
                prdata_q <= 32'h0000_0000;
        end
    end

    // Outputs
    assign prdata_o       = prdata_q;
    assign pready_o       = 1'b1;
    assign pslverr_o      = psel_i & penable_i & err_q;
    assign arr_rdata_o    = rdata_q;
    assign hv_on_o        = ctrl_q[`FPEC_B_HV];
    assign pump_div_low_o = ctrl_q[`FPEC_B_DIVLO];
    assign erase_size_o   = ctrl_q[`FPEC_B_SZHI:`FPEC_B_SZLO];
    assign erase_mode_o   = ctrl_q[`FPEC_B_ERASE];
    assign prog_mode_o    = ctrl_q[`FPEC_B_PGM];
    assign margin_o       = ctrl_q[`FPEC_B_MARGIN_SELECT];
    assign target_addr_o  = tgt_q;
    assign target_valid_o = tgt_v_q;
    // Row index within the first array, 64 bytes a row
    assign target_row_o   = 9'(16'(tgt_q - `FPEC_A1_LO) >> 6);
    assign page_mask_o    = mask_q;
    for (genvar g = 0; g < 8; g++)
    begin : g_page
        assign page_data_o[g*8 +: 8] = page_buf_q[g];
    end

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    a_sel_exclusive: assert property (!(prog_mode_o && erase_mode_o))
        else $error("program and erase both selected");
    a_both_refused: assert property (wr_ctrl && both_sel |=> $stable(prog_mode_o))
        else $error("double select write changed program bit");
    a_hv_needs_sel: assert property ($rose(hv_on_o) |-> $past(prog_mode_o || erase_mode_o))
        else $error("high voltage set without a mode");
    a_margin_select_hv_excl: assert property (hv_on_o |=> !margin_o)
        else $error("margin held while high voltage on");
    a_margin_select_refused: assert property (wr_ctrl && hv_on_o && wd[`FPEC_B_MARGIN_SELECT] |=> !margin_o)
        else $error("margin set while high voltage on");
    a_prot_clears: assert property (hit_ers || hit_pgm |=>
        !(prog_mode_o || erase_mode_o) && !hv_on_o ##1 !hv_on_o)
        else $error("protected target kept select");
    a_row_align: assert property (target_valid_o && erase_mode_o |-> target_addr_o[5:0] == 6'h00)
        else $error("erase target not row aligned");
    a_page_align: assert property (target_valid_o && prog_mode_o |-> target_addr_o[2:0] == 3'h0)
        else $error("program target not page aligned");
    a_full_any: assert property (arr_wr && erase_mode_o && !hit_ers && erase_size_o == 2'b00
                                 |=> target_addr_o == 16'h8000)
        else $error("full erase target wrong");
    a_read_sense: assert property (ar_i |=> arr_rdata_o == ~$past(cell_erased_i))
        else $error("array read polarity wrong");

    c_erase_latch: cover property (erase_mode_o && !target_valid_o ##1 target_valid_o ##[1:20] hv_on_o);
    c_prog_page: cover property (prog_mode_o && page_mask_o == 8'hFF);
    c_prot_block: cover property (hit_pgm || hit_ers);
    c_margin_select_drop: cover property (margin_o ##1 hv_on_o);

endmodule : fpec_ctrl
`default_nettype wire

// File: testbench/fpec_arr_model.sv
// Flash array sense model facing the array read port
`timescale 1ns/1ps
`default_nettype none
module fpec_arr_model (
    // Clock and read strobe
    input  wire logic       mclk_i,
    input  wire logic       ar_i,
    // Programmed-bit image and raw sense
    input  wire logic [7:0] cell_prog_i,
    output logic [7:0]      cell_erased_o
);
    logic [7:0] junk_q = 8'hA5;
    // Sense is only good in a read cycle, so idle shows a moving pattern
    always @(posedge mclk_i)
    begin
        junk_q <= junk_q + 8'h5B;
    end
    // Raw sense: 1 means erased, so programmed ones come back inverted
    assign cell_erased_o = ar_i ? ~cell_prog_i : junk_q;
endmodule : fpec_arr_model
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
`default_nettype none
`include "fpec_cfg.svh"
module tb_top;
    logic        mclk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0]  pstrb_i = 4'hF;
    logic        aw_i = 1'b0, ar_i = 1'b0, pready_o, pslverr_o, err;
    logic [15:0] aw_addr_i = 16'h0, target_addr_o;
    logic [7:0]  aw_data_i = 8'h0, cell_erased_i, arr_rdata_o, page_mask_o;
    logic [7:0]  cell_prog = 8'h00;
    logic        hv_on_o, pump_div_low_o, erase_mode_o, prog_mode_o, margin_o;
    logic        target_valid_o;
    logic [1:0]  erase_size_o;
    logic [8:0]  target_row_o;
    logic [63:0] page_data_o;
    int          n_fail = 0, check_count = 0;

    // Block under test and the array sense model
    fpec_ctrl dut_u (
        .mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .aw_i(aw_i),
        .aw_addr_i(aw_addr_i), .aw_data_i(aw_data_i), .ar_i(ar_i),
        .cell_erased_i(cell_erased_i), .arr_rdata_o(arr_rdata_o), .hv_on_o(hv_on_o),
        .pump_div_low_o(pump_div_low_o), .erase_size_o(erase_size_o),
        .erase_mode_o(erase_mode_o), .prog_mode_o(prog_mode_o), .margin_o(margin_o),
        .target_addr_o(target_addr_o), .target_valid_o(target_valid_o),
        .target_row_o(target_row_o), .page_data_o(page_data_o), .page_mask_o(page_mask_o)
    );
    fpec_arr_model arr_u (.mclk_i(mclk_i), .ar_i(ar_i), .cell_prog_i(cell_prog),
        .cell_erased_o(cell_erased_i));

    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung access
        do
            @(posedge mclk_i);
        while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    // Control write then read back, so outputs have settled afterwards
    // Only the control register is touched by this task
    task automatic ctl(input logic [7:0] v);
        apb(1'b1, `FPEC_OFF_CTRL, {24'h0, v});
        apb(1'b0, `FPEC_OFF_CTRL, 32'h0);
    endtask : ctl

    task automatic arr_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        aw_i <= 1'b1;
        aw_addr_i <= a;
        aw_data_i <= d;
        @(posedge mclk_i);
        aw_i <= 1'b0;
        @(posedge mclk_i);
    endtask : arr_wr

    function automatic logic [15:0] erase_base(input logic [1:0] sz, input logic [15:0] a);
        case (sz)
            2'b00: erase_base = `FPEC_A1_LO;
            2'b01: erase_base = a & ~`FPEC_HALF_MASK;
            2'b10: erase_base = a & ~`FPEC_OCT_MASK;
            default: erase_base = a & ~`FPEC_ROW_MASK;
        endcase
    endfunction : erase_base

    task automatic end_test(input string s);
        $display("test %s done at %0t", s, $time);
    endtask : end_test

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    // Main sequence
    initial
    begin
        logic [15:0] a;
        logic [15:0] b;
        logic [7:0]  v;
        void'($urandom(59));
        repeat (6) @(posedge mclk_i);
        srst_i <= 1'b0;
        apb(1'b0, `FPEC_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd, 31'h0, err}, {32'h0, 32'h1});
        // Write without the low byte strobe must be ignored
        pstrb_i <= 4'hE;
        apb(1'b1, `FPEC_OFF_CTRL, 32'h41);
        pstrb_i <= 4'hF;
        apb(1'b0, `FPEC_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        end_test("reset");
        ctl(8'h03);
        chk(rd, 32'h0);
        ctl(8'h08);
        chk({rd, 31'h0, hv_on_o}, 64'h0);
        ctl(8'h05);
        chk({rd, 31'h0, margin_o}, {32'h5, 32'h1});
        ctl(8'h0D);
        chk({rd, 30'h0, hv_on_o, margin_o}, {32'h9, 32'h2});
        ctl(8'h0F);
        chk(rd, 32'h9);
        arr_wr(16'h8100, 8'h11);
        chk(target_valid_o, 1'b0);
        ctl(8'h00);
        end_test("interlock");
        ctl(8'h01);
        v = 8'($urandom);
        arr_wr(16'h8013, 8'h5A);
        arr_wr(16'h8014, v);
        chk({target_addr_o, target_row_o, page_mask_o, target_valid_o},
            {16'h8010, 9'h0, 8'h18, 1'b1});
        chk(page_data_o[39:24], {v, 8'h5A});
        // Short high-voltage pulse, array writes refused meanwhile
        ctl(8'h09);
        chk(hv_on_o, 1'b1);
        arr_wr(16'h8040, 8'h12);
        chk(target_addr_o, 16'h8010);
        ctl(8'h01);
        chk(hv_on_o, 1'b0);
        arr_wr(16'h8021, 8'h77);
        chk(page_mask_o, 8'h02);
        apb(1'b0, `FPEC_OFF_ADDR, 32'h0);
        chk(rd, 32'h8020);
        apb(1'b0, `FPEC_OFF_STAT, 32'h0);
        chk(rd, 32'h203);
        arr_wr(16'h3E48, 8'h99);
        chk({target_addr_o, page_mask_o}, {16'h8020, 8'h02});
        // Mid-run reset drops latch, mask and modes
        srst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        chk({target_valid_o, page_mask_o, prog_mode_o, hv_on_o}, 11'h0);
        ctl(8'h00);
        chk(target_valid_o, 1'b0);
        end_test("program");
        // Random erase targets and divide bits, every erase size setting
        for (int k = 0; k < 8; k++)
        begin
            v = {2'($urandom), 2'(k), 4'h2};
            a = 16'h8000 + 16'($urandom % 32'h7E00);
            if (k == 0)
                a = 16'hFFE0;
            ctl(v);
            chk(rd, {24'h0, v});
            arr_wr(a, 8'h00);
            b = erase_base(v[5:4], a);
            chk({erase_size_o, pump_div_low_o, target_addr_o}, {v[5:4], v[6], b});
            b = b - 16'h8000;
            chk(target_row_o, b[14:6]);
            ctl(8'h00);
        end
        end_test("erase");
        apb(1'b1, `FPEC_OFF_PROT, 32'h8);
        ctl(8'h32);
        arr_wr(16'hC040, 8'h00);
        chk(erase_mode_o, 1'b0);
        ctl(8'h3A);
        chk(rd, 32'h32);
        ctl(8'h00);
        ctl(8'h01);
        arr_wr(16'h8008, 8'h33);
        chk(prog_mode_o, 1'b1);
        arr_wr(16'hC008, 8'h44);
        chk(prog_mode_o, 1'b0);
        ctl(8'h09);
        chk(rd, 32'h1);
        ctl(8'h00);
        apb(1'b1, `FPEC_OFF_PROT, 32'h0);
        end_test("protect");
        // Read back in margin mode
        ctl(8'h04);
        chk(margin_o, 1'b1);
        @(posedge mclk_i);
        ar_i <= 1'b1;
        cell_prog <= 8'($urandom);
        @(posedge mclk_i);
        ar_i <= 1'b0;
        @(posedge mclk_i);
        chk(arr_rdata_o, cell_prog);
        end_test("read");
        final_report();
    end

    // Watchdog: the run needs well under 2000 cycles
    initial
    begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
